// ---- core/gpmux_consts.svh ----
// Purpose: offsets, field positions, reset values and codes of the pin mux
// Assumes: byte-wide register port, 8-bit addresses
// Notes: definitions only
`ifndef GPMUX_CONSTS_SVH
`define GPMUX_CONSTS_SVH

`define GPMUX_OFS_PIN_CTRL 8'h60
`define GPMUX_OFS_PIN0_SEL 8'h61
`define GPMUX_OFS_PIN1_SEL 8'h62
`define GPMUX_OFS_PIN2_SEL 8'h63
`define GPMUX_OFS_IN_ROUTE 8'h64
`define GPMUX_OFS_OUT_LEVEL 8'h65
`define GPMUX_OFS_OUT_INV 8'h66
`define GPMUX_OFS_IDENT 8'h67

`define GPMUX_RST_REG 8'h00

`define GPMUX_ROUTE_POCI_LSB 6
`define GPMUX_ROUTE_SYNC_LSB 4
`define GPMUX_ROUTE_RST_LSB 2
`define GPMUX_ROUTE_MUTE_LSB 0

`define GPMUX_SEL_LOW 4'h0
`define GPMUX_SEL_LEVEL 4'h2
`define GPMUX_SEL_MUTE_BOTH 4'h3
`define GPMUX_SEL_MUTE_L 4'h4
`define GPMUX_SEL_MUTE_R 4'h5
`define GPMUX_SEL_CLK_BAD 4'h6
`define GPMUX_SEL_WARN 4'h8
`define GPMUX_SEL_AUDIO_OUT 4'h9
`define GPMUX_SEL_CODE_B 4'hB
`define GPMUX_SEL_CODE_C 4'hC
`define GPMUX_SEL_CODE_D 4'hD

`define GPMUX_PICK_NONE 2'h0
`define GPMUX_PICK_PIN2 2'h3

`endif

// ---- core/gpmux_pkg.sv ----
// Purpose: types of the pin mux
// Assumes: three general pins
// Notes: constants live in gpmux_consts.svh
package gpmux_pkg;

  typedef struct packed {
    logic mute_l;
    logic mute_r;
    logic clk_bad;
    logic warn_n;
    logic fault_n;
    logic serial_audio_data_out;
    logic spi_clk;
    logic spi_pico;
  } gpmux_flags_type;

  typedef struct packed {
    logic [7:0] pin_ctrl;
    logic [7:0] sel0;
    logic [7:0] sel1;
    logic [7:0] sel2;
    logic [7:0] in_route;
    logic [7:0] out_level;
    logic [7:0] out_inv;
  } gpmux_regs_type;

  typedef struct packed {
    logic poci;
    logic phase_sync;
    logic reset_n;
    logic mute_n;
  } gpmux_inputs_type;

endpackage : gpmux_pkg

// ---- core/gpmux_pin_select.sv ----
// Purpose: one pin's output function selector with inversion
// Assumes: flags synchronous to i_clk
// Notes: pin zero uses a different code set for fault and spi clock
`timescale 1ns/1ns
`include "gpmux_consts.svh"
module gpmux_pin_select
  import gpmux_pkg::*;
#(
  parameter bit IS_PIN0 = 1'b0
) (
  // selection
  input wire logic [3:0] i_sel,
  input wire logic i_level,
  input wire logic i_inv,
  // flags
  input wire gpmux_flags_type i_flags,
  // result
  output logic o_value
);

  logic raw;

  always_comb begin
    raw = 1'b0;
    case (i_sel)
      `GPMUX_SEL_LOW: raw = 1'b0;
      `GPMUX_SEL_LEVEL: raw = i_level;
      `GPMUX_SEL_MUTE_BOTH: raw = i_flags.mute_l & i_flags.mute_r;
      `GPMUX_SEL_MUTE_L: raw = i_flags.mute_l;
      `GPMUX_SEL_MUTE_R: raw = i_flags.mute_r;
      `GPMUX_SEL_CLK_BAD: raw = i_flags.clk_bad;
      `GPMUX_SEL_WARN: raw = i_flags.warn_n;
      `GPMUX_SEL_AUDIO_OUT: raw = i_flags.serial_audio_data_out;
      `GPMUX_SEL_CODE_B: begin
        raw = IS_PIN0 ? i_flags.fault_n : i_flags.spi_clk;
      end
      `GPMUX_SEL_CODE_C: raw = IS_PIN0 ? i_flags.spi_clk : 1'b0;
      `GPMUX_SEL_CODE_D: raw = i_flags.spi_pico;
      default: raw = 1'b0;
    endcase
  end

  assign o_value = raw ^ i_inv;

endmodule : gpmux_pin_select

// ---- core/gpmux_top.sv ----
// Purpose: general pin function multiplexer with its control registers
// Assumes: byte register port from the control interface, one clock
// Notes: pin outputs registered; input routing combinational from pins
// Functional notes
// - Selector 0000 drives the pin low and 0010 drives the software level.
// - Code 0011 outputs auto-mute only when both channels are muted.
// - Code 0100 outputs left auto-mute and 0101 right auto-mute.
// - Code 0110 outputs the clock-invalid indication.
// - Code 1000 outputs the active-low warning.
// - Code 1001 outputs the serial audio data stream.
// - On pins one and two, 1011 gives spi clock and 1101 spi data out.
// - Two-bit fields pick no pin or pin 0, 1, 2 for poci and phase sync.
// - Bits 3-2 pick the reset pin; with pin two its config survives it.
// - Bits 1-0 pick the mute pin; low mutes and tristates the drivers.
// - The level register holds one bit per pin, upper bits as stored.
// - The invert register flips the driven level of each pin.
// - The read-only identification register ignores writes.
// - Each pin has an enable bit: 0 input, 1 driven by its selector.
// - Pin zero gives fault at 1011, spi clock 1100, spi data 1101.
`timescale 1ns/1ns
`include "gpmux_consts.svh"
module gpmux_top
  import gpmux_pkg::*;
#(
  parameter logic [7:0] IDENT_VALUE = 8'h5A // arbitrary value
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // internal flags
  input wire gpmux_flags_type i_flags,
  // general pins
  input wire logic [2:0] i_pin,
  output logic [2:0] o_pin,
  output logic [2:0] o_pin_oe,
  // routed inputs
  output gpmux_inputs_type o_inputs,
  output logic o_amp_hiz
);

  typedef struct packed {
    gpmux_regs_type regs;
    logic [2:0] pin;
    logic [2:0] oe;
  } gpmux_state_type;

  gpmux_state_type st_q;
  gpmux_state_type st_d;
  logic [2:0] pin_val;
  logic [7:0] rdata;
  logic pin_rst_n;

  function automatic logic pick_pin(input logic [1:0] code,
                                    input logic [2:0] pins);
    logic r;
    r = 1'b0;
    case (code)
      2'h1: r = pins[0];
      2'h2: r = pins[1];
      2'h3: r = pins[2];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_pin

  function automatic logic pick_n(input logic [1:0] code,
                                  input logic [2:0] pins);
    logic r;
    r = 1'b1;
    if (code != `GPMUX_PICK_NONE) begin
      r = pick_pin(code, pins);
    end
    return r;
  endfunction : pick_n

  gpmux_pin_select #(.IS_PIN0(1'b1)) u_sel0 (
    .i_sel(st_q.regs.sel0[3:0]),
    .i_level(st_q.regs.out_level[0]),
    .i_inv(st_q.regs.out_inv[0]),
    .i_flags(i_flags),
    .o_value(pin_val[0])
  );
  gpmux_pin_select #(.IS_PIN0(1'b0)) u_sel1 (
    .i_sel(st_q.regs.sel1[3:0]),
    .i_level(st_q.regs.out_level[1]),
    .i_inv(st_q.regs.out_inv[1]),
    .i_flags(i_flags),
    .o_value(pin_val[1])
  );
  gpmux_pin_select #(.IS_PIN0(1'b0)) u_sel2 (
    .i_sel(st_q.regs.sel2[3:0]),
    .i_level(st_q.regs.out_level[2]),
    .i_inv(st_q.regs.out_inv[2]),
    .i_flags(i_flags),
    .o_value(pin_val[2])
  );

  // routed inputs; a pin driven by us reads back its own level
  logic [1:0] rte_poci;
  logic [1:0] rte_sync;
  logic [1:0] rte_rst;
  logic [1:0] rte_mute;
  assign rte_poci = st_q.regs.in_route[`GPMUX_ROUTE_POCI_LSB +: 2];
  assign rte_sync = st_q.regs.in_route[`GPMUX_ROUTE_SYNC_LSB +: 2];
  assign rte_rst = st_q.regs.in_route[`GPMUX_ROUTE_RST_LSB +: 2];
  assign rte_mute = st_q.regs.in_route[`GPMUX_ROUTE_MUTE_LSB +: 2];

  always_comb begin
    o_inputs.poci = pick_pin(rte_poci, i_pin);
    o_inputs.phase_sync = pick_pin(rte_sync, i_pin);
    o_inputs.reset_n = pick_n(rte_rst, i_pin);
    o_inputs.mute_n = pick_n(rte_mute, i_pin);
  end

  assign pin_rst_n = o_inputs.reset_n;
  assign o_amp_hiz = ~o_inputs.mute_n;

  always_comb begin
    case (i_reg_addr)
      `GPMUX_OFS_PIN_CTRL: rdata = st_q.regs.pin_ctrl;
      `GPMUX_OFS_PIN0_SEL: rdata = st_q.regs.sel0;
      `GPMUX_OFS_PIN1_SEL: rdata = st_q.regs.sel1;
      `GPMUX_OFS_PIN2_SEL: rdata = st_q.regs.sel2;
      `GPMUX_OFS_IN_ROUTE: rdata = st_q.regs.in_route;
      `GPMUX_OFS_OUT_LEVEL: rdata = st_q.regs.out_level;
      `GPMUX_OFS_OUT_INV: rdata = st_q.regs.out_inv;
      `GPMUX_OFS_IDENT: rdata = IDENT_VALUE;
      default: rdata = 8'h00;
    endcase
  end

  always_comb begin
    st_d = st_q;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `GPMUX_OFS_PIN_CTRL: st_d.regs.pin_ctrl = i_reg_wdata;
        `GPMUX_OFS_PIN0_SEL: st_d.regs.sel0 = i_reg_wdata;
        `GPMUX_OFS_PIN1_SEL: st_d.regs.sel1 = i_reg_wdata;
        `GPMUX_OFS_PIN2_SEL: st_d.regs.sel2 = i_reg_wdata;
        `GPMUX_OFS_IN_ROUTE: st_d.regs.in_route = i_reg_wdata;
        `GPMUX_OFS_OUT_LEVEL: st_d.regs.out_level = i_reg_wdata;
        `GPMUX_OFS_OUT_INV: st_d.regs.out_inv = i_reg_wdata;
        default: st_d.regs = st_q.regs;
      endcase
    end
    // pin reset clears pin configuration, pin two spared when it is source
    if (!pin_rst_n) begin
      st_d.regs.sel0 = `GPMUX_RST_REG;
      st_d.regs.sel1 = `GPMUX_RST_REG;
      st_d.regs.out_level[1:0] = 2'h0;
      st_d.regs.out_inv[1:0] = 2'h0;
      st_d.regs.pin_ctrl[1:0] = 2'h0;
      if (rte_rst != `GPMUX_PICK_PIN2) begin
        st_d.regs.sel2 = `GPMUX_RST_REG;
        st_d.regs.out_level[2] = 1'b0;
        st_d.regs.out_inv[2] = 1'b0;
        st_d.regs.pin_ctrl[2] = 1'b0;
      end
    end
    st_d.pin = pin_val;
    st_d.oe = st_d.regs.pin_ctrl[2:0];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_pin = st_q.pin;
  assign o_pin_oe = st_q.oe;
  assign o_reg_rdata = rdata;

  a_sel_low_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel1[3:0] == 4'h0 && !st_q.regs.out_inv[1])
    |=> o_pin[1] == 1'b0)
    else $error("pin1 not low with code 0");
  a_level_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel2[3:0] == 4'h2)
    |=> o_pin[2] == ($past(st_q.regs.out_level[2]) ^
                     $past(st_q.regs.out_inv[2])))
    else $error("pin2 level mismatch");
  a_mute_both: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel0[3:0] == 4'h3 && !st_q.regs.out_inv[0])
    |=> o_pin[0] == $past(i_flags.mute_l & i_flags.mute_r))
    else $error("combined mute wrong");
  a_mute_right: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel1[3:0] == 4'h5 && !st_q.regs.out_inv[1])
    |=> o_pin[1] == $past(i_flags.mute_r))
    else $error("right mute wrong");
  a_clk_bad: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel1[3:0] == 4'h6 && !st_q.regs.out_inv[1])
    |=> o_pin[1] == $past(i_flags.clk_bad))
    else $error("clock invalid wrong");
  a_spi_clk_p1: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel1[3:0] == 4'hB && !st_q.regs.out_inv[1])
    |=> o_pin[1] == $past(i_flags.spi_clk))
    else $error("spi clock wrong on pin1");
  a_fault_p0: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel0[3:0] == 4'hB && st_q.regs.out_inv[0])
    |=> o_pin[0] == !$past(i_flags.fault_n))
    else $error("fault inverted wrong");
  a_mute_hiz: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rte_mute == 2'h2 && !i_pin[1]) |-> o_amp_hiz)
    else $error("mute pin ignored");
  a_die_ro: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_addr == 8'h67) |-> o_reg_rdata == IDENT_VALUE)
    else $error("die_identification changed");
  a_pin2_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rte_rst == 2'h3 && !i_reg_wr)
    |=> st_q.regs.sel2 == $past(st_q.regs.sel2))
    else $error("pin2 config cleared");
  a_oe_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == `GPMUX_OFS_PIN_CTRL && pin_rst_n)
    |=> o_pin_oe == $past(i_reg_wdata[2:0]))
    else $error("enable write lost");

  // further selector codes
  a_mute_left: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel2[3:0] == 4'h4 && !st_q.regs.out_inv[2])
    |=> o_pin[2] == $past(i_flags.mute_l))
    else $error("left mute wrong");
  a_warn_p2: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel2[3:0] == 4'h8 && !st_q.regs.out_inv[2])
    |=> o_pin[2] == $past(i_flags.warn_n))
    else $error("warning wrong");
  a_audio_p0: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel0[3:0] == 4'h9 && !st_q.regs.out_inv[0])
    |=> o_pin[0] == $past(i_flags.serial_audio_data_out))
    else $error("audio data wrong");
  a_pico_p2: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel2[3:0] == 4'hD && !st_q.regs.out_inv[2])
    |=> o_pin[2] == $past(i_flags.spi_pico))
    else $error("spi data wrong on pin2");
  a_spi_clk_p0: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel0[3:0] == 4'hC && !st_q.regs.out_inv[0])
    |=> o_pin[0] == $past(i_flags.spi_clk))
    else $error("spi clock wrong on pin0");
  a_pico_p0: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel0[3:0] == 4'hD && st_q.regs.out_inv[0])
    |=> o_pin[0] == !$past(i_flags.spi_pico))
    else $error("spi data wrong on pin0");
  a_code_c_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel1[3:0] == 4'hC)
    |=> o_pin[1] == $past(st_q.regs.out_inv[1]))
    else $error("code c not low on pin1");
  a_rsvd_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel2[3:0] inside {4'h1, 4'h7, 4'hA, 4'hE, 4'hF})
    |=> o_pin[2] == $past(st_q.regs.out_inv[2]))
    else $error("reserved code not low");
  a_inv_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel0[3:0] == 4'h0)
    |=> o_pin[0] == $past(st_q.regs.out_inv[0]))
    else $error("inverted low wrong");
  a_level_p0: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel0[3:0] == 4'h2 && !st_q.regs.out_inv[0])
    |=> o_pin[0] == $past(st_q.regs.out_level[0]))
    else $error("pin0 level wrong");
  a_level_p1: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_q.regs.sel1[3:0] == 4'h2 && !st_q.regs.out_inv[1])
    |=> o_pin[1] == $past(st_q.regs.out_level[1]))
    else $error("pin1 level wrong");

  // routed reset, routing and register writes
  a_rst_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !pin_rst_n
    |=> st_q.regs.sel0 == 8'h00 && st_q.regs.sel1 == 8'h00)
    else $error("pin reset left config");
  a_rst_pin2: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!pin_rst_n && rte_rst != 2'h3)
    |=> st_q.regs.sel2 == 8'h00 && o_pin_oe[2] == 1'b0)
    else $error("pin2 config kept");
  a_poci_route: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rte_poci == 2'h2) |-> o_inputs.poci == i_pin[1])
    else $error("poci routing wrong");
  a_sync_route: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rte_sync == 2'h1) |-> o_inputs.phase_sync == i_pin[0])
    else $error("sync routing wrong");
  a_unrouted: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rte_poci == 2'h0 && rte_sync == 2'h0)
    |-> !o_inputs.poci && !o_inputs.phase_sync)
    else $error("unrouted input active");
  a_rst_route: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rte_rst == 2'h3) |-> o_inputs.reset_n == i_pin[2])
    else $error("reset routing wrong");
  a_mute_none: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rte_mute == 2'h0) |-> !o_amp_hiz)
    else $error("mute without source");
  a_level_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == `GPMUX_OFS_OUT_LEVEL && pin_rst_n)
    |=> st_q.regs.out_level == $past(i_reg_wdata))
    else $error("level write lost");
  a_inv_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == `GPMUX_OFS_OUT_INV && pin_rst_n)
    |=> st_q.regs.out_inv == $past(i_reg_wdata))
    else $error("invert write lost");

endmodule : gpmux_top

// ---- verification/gpmux_pin_env.sv ----
// Purpose: external circuit on the three general pins
// Assumes: outside parts drive a pin only while the mux releases it
// Notes: pin level seen by the mux combines both drivers
`timescale 1ns/1ns
module gpmux_pin_env (
  // outside levels
  input wire logic [2:0] i_ext,
  // mux side
  input wire logic [2:0] i_drv,
  input wire logic [2:0] i_drv_oe,
  // resolved pins
  output logic [2:0] o_pin
);
  // enabled pin follows the mux, released pin the outside
  assign o_pin = (i_drv & i_drv_oe) | (i_ext & ~i_drv_oe);
endmodule : gpmux_pin_env

// ---- verification/tb.sv ----
// Purpose: self-checking bench for the general pin function mux
// Assumes: inputs change at the falling edge
// Notes: drivers queue expectations, a monitor compares them
`timescale 1ns/1ns
module tb
  import gpmux_pkg::*;
;
  typedef struct {int kind; logic [7:0] val;} gpmux_note_type;
  localparam logic [7:0] DIE_VAL = 8'h3C; // arbitrary value
  logic clk, rst_n, wr, hiz;
  logic [7:0] addr, wdata, rdata, v, x;
  logic [2:0] pin, ext, opin, oe, lvl, inv, e;
  logic [3:0] sel [3];
  gpmux_flags_type flags;
  gpmux_inputs_type ins;
  gpmux_note_type q[$];
  event ev;
  int error_cnt, checks, seed;

  gpmux_top #(.IDENT_VALUE(DIE_VAL)) u_gpmux_top (.i_clk(clk),
    .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_flags(flags), .i_pin(pin), .o_pin(opin),
    .o_pin_oe(oe), .o_inputs(ins), .o_amp_hiz(hiz));
  gpmux_pin_env u_gpmux_pin_env (.i_ext(ext), .i_drv(opin), .i_drv_oe(oe),
    .o_pin(pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp_v,
                     input string what);
    checks++;
    if (got !== exp_v) begin
      error_cnt++;
      $display("unexpected at %0t: %s %h want %h", $time, what, got, exp_v);
    end
  endtask : cmp

  task automatic cmp_reg(input logic [7:0] exp_v);
    cmp(rdata, exp_v, "read data");
  endtask : cmp_reg

  task automatic cmp_pin(input logic [7:0] exp_v);
    cmp({5'h00, opin}, exp_v, "pin levels");
  endtask : cmp_pin

  task automatic cmp_in(input logic [7:0] exp_v);
    cmp({3'h0, hiz, ins}, exp_v, "routed inputs");
  endtask : cmp_in

  task automatic cmp_oe(input logic [7:0] exp_v);
    cmp({5'h00, oe}, exp_v, "pin enables");
  endtask : cmp_oe

  always @(ev) begin : monitor
    gpmux_note_type n;
    n = q.pop_front();
    case (n.kind)
      0: cmp_reg(n.val);
      1: cmp_pin(n.val);
      2: cmp_in(n.val);
      default: cmp_oe(n.val);
    endcase
  end

  task automatic note(input int k, input logic [7:0] val);
    q.push_back('{k, val});
    ->ev;
    #1;
  endtask : note

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] val);
    @(negedge clk);
    addr = a;
    #2;
    note(0, val);
  endtask : rd_reg

  task automatic chk_pin(input logic [2:0] val);
    repeat (2) @(negedge clk);
    note(1, {5'h00, val});
  endtask : chk_pin

  function automatic logic exp_out(int p, logic [3:0] c, gpmux_flags_type f,
                                   logic l);
    case (c)
      4'h2: return l;
      4'h3: return f.mute_l & f.mute_r;
      4'h4: return f.mute_l;
      4'h5: return f.mute_r;
      4'h6: return f.clk_bad;
      4'h8: return f.warn_n;
      4'h9: return f.serial_audio_data_out;
      4'hB: return (p == 0) ? f.fault_n : f.spi_clk;
      4'hC: return (p == 0) ? f.spi_clk : 1'b0;
      4'hD: return f.spi_pico;
      default: return 1'b0;
    endcase
  endfunction : exp_out

  initial begin
    #200000;
    error_cnt++;
    $display("unexpected at %0t: timeout", $time);
    report_and_stop();
  end

  initial begin
    seed = 44553;
    rst_n = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    flags = 8'h00;
    ext = 3'h7;
    repeat (16) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    for (int a = 8'h60; a < 8'h67; a++) rd_reg(a[7:0], 8'h00);
    rd_reg(8'h68, 8'h00);
    wr_reg(8'h67, 8'hFF);
    rd_reg(8'h67, DIE_VAL);
    chk_pin(3'h0);
    $display("test reset_values done");
    for (int a = 8'h60; a < 8'h67; a++) begin
      v = 8'($random(seed));
      if (a == 8'h64) v[3:2] = 2'h0;
      wr_reg(a[7:0], v);
      rd_reg(a[7:0], v);
      if (a == 8'h60) note(3, {5'h00, v[2:0]});
    end
    for (int a = 8'h61; a < 8'h65; a++) wr_reg(a[7:0], 8'h00);
    wr_reg(8'h60, 8'h07);
    note(3, 8'h07);
    $display("test register_storage done");
    for (int i = 0; i < 3; i++) sel[i] = 4'h0;
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 16; c++) begin
        v = 8'($random(seed));
        sel[p] = c[3:0];
        wr_reg(8'h61 + p[7:0], {v[7:4], c[3:0]});
        v = 8'($random(seed));
        lvl = v[2:0];
        wr_reg(8'h65, v);
        v = 8'($random(seed));
        inv = v[2:0];
        wr_reg(8'h66, v);
        @(negedge clk) flags = 8'($random(seed));
        for (int i = 0; i < 3; i++) e[i] = exp_out(i, sel[i], flags, lvl[i]);
        chk_pin(e ^ inv);
      end
    end
    $display("test selector_codes done");
    wr_reg(8'h60, 8'h00);
    note(3, 8'h00);
    for (int k = 0; k < 12; k++) begin
      v = 8'($random(seed));
      @(negedge clk) ext = v[2:0];
      wr_reg(8'h64, {4{k[1:0]}});
      x = (k % 4 == 0) ? 8'h03 : {3'h0, ~ext[k % 4 - 1], {4{ext[k % 4 - 1]}}};
      #2;
      note(2, x);
    end
    $display("test input_routing done");
    @(negedge clk) ext = 3'h7;
    wr_reg(8'h62, 8'h05);
    wr_reg(8'h63, 8'h05);
    wr_reg(8'h65, 8'h07);
    wr_reg(8'h66, 8'h07);
    wr_reg(8'h64, 8'h0C);
    @(negedge clk) ext = 3'h3;
    @(negedge clk) ext = 3'h7;
    rd_reg(8'h62, 8'h00);
    rd_reg(8'h63, 8'h05);
    rd_reg(8'h65, 8'h04);
    rd_reg(8'h66, 8'h04);
    wr_reg(8'h64, 8'h08);
    @(negedge clk) ext = 3'h5;
    @(negedge clk) ext = 3'h7;
    rd_reg(8'h63, 8'h00);
    rd_reg(8'h65, 8'h00);
    $display("test routed_reset done");
    report_and_stop();
  end
endmodule : tb
